// ---- filter_console_model.sv ----
/*
 * Console model for the debounce filter: writes all group settings in one go and reads them back.
 * Assumes the filter's console strobes are sampled on the rising edge of mclk.
 */
module filter_console_model
    import input_filter_pkg::*;
(
    input  wire logic         mclk,               // System clock.
    input  wire logic         writeAck,           // Write accepted pulse.
    input  wire logic         writeRefused,       // Write refused pulse.
    input  wire logic         readValid,          // Readback pulse.
    input  wire filter_set_t  readData,           // Readback settings.
    output logic              writeStrobe,        // Write request.
    output filter_set_t       writeData,          // Settings of all groups.
    output logic              readStrobe,         // Readback request.
    output logic              programModeSetting  // High in program mode.
);
    timeunit 1ns;
    timeprecision 1ps;
    filter_set_t heldCopy;  // Console's own copy of the settings.

    // Idle console in run mode with matching copy of the reset settings.
    initial begin
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
        writeData = 6'h00;
        programModeSetting = 1'b0;
        heldCopy = 6'h00;
    end

    // Mode changes happen just after an edge.
    task automatic setMode(input logic m);
        @(posedge mclk);
        #1 programModeSetting = m;
    endtask

    // One write carries all three groups; the copy moves only when the device accepts it.
    task automatic sendSettings(input filter_set_t d, output logic ack, output logic refd);
        @(posedge mclk);
        #1 writeStrobe = 1'b1;
        writeData = d;
        @(posedge mclk);
        #1 writeStrobe = 1'b0;
        writeData = ~d;
        ack = writeAck;
        refd = writeRefused;
        if (ack !== 1'b1 && refd !== 1'b1) begin
            @(posedge mclk);
            #1 ack = writeAck;
            refd = writeRefused;
        end
        if (ack === 1'b1) heldCopy = d;
    endtask

    // Readback request; the answer is taken one cycle later.
    task automatic readSettings(output filter_set_t q, output logic ok);
        @(posedge mclk);
        #1 readStrobe = 1'b1;
        @(posedge mclk);
        #1 readStrobe = 1'b0;
        ok = readValid;
        if (ok !== 1'b1) begin
            @(posedge mclk);
            #1 ok = readValid;
        end
        q = readData;
    endtask
endmodule

// ---- grouped_input_debounce_filter.sv ----
/*
 * Grouped input debounce filter: per-input qualification counters whose length
 * follows a per-group 2-bit setting, with console write and readback ports.
 * Assumes a 250 MHz mclk, raw inputs from pins, console strobes on mclk.
 */
`include "input_filter_params.svh"

// Overview of operation
// (R1) Pulses shorter than the group's selected minimum width never reach the output.
// (R2) Codes 0,1,2,3 select 0, 1, 5 and 10 ms minimum width.
// (R3) Zero setting detects after about 150 us; others at the nominal time.
// (R4) Pulses near the nominal time may be accepted or rejected.
// (R5) Each group holds its own setting, applied only to its own inputs.
// (R6) Group membership follows the six, ten or twelve input variant.
// (R7) Settings are written only in program mode, refused in run mode.
// (R8) Current settings can be read back in run or program mode.
// (R9) The console writes all group settings in one operation.
// (R10) After a write both console and device hold the same values.
// (R11) Six-input readback reports groups 1 and 2; others report all three.
// (R12) Operators should pick 5 or 10 ms in noisy installations.
// (R13) Output changes only after the new level holds for the full duration.
module grouped_input_debounce_filter
    import input_filter_pkg::*;
#(
    parameter logic [1:0] VARIANT = `VARIANT_TWELVE  // Input count variant.
) (
    input  wire logic                     mclk,          // System clock, 250 MHz.
    input  wire logic                     rst_n,         // Asynchronous reset, active low.
    input  wire logic [`NUM_INPUTS-1:0]   rawInputs,     // Raw input terminals.
    input  wire logic                     programModeSetting, // High in program mode.
    input  wire logic                     writeStrobe,   // Console write of all groups.
    input  wire filter_set_t              writeData,     // Settings for all groups.
    input  wire logic                     readStrobe,    // Console readback request.
    output logic [`NUM_INPUTS-1:0]        filteredInputs, // Debounced inputs.
    output filter_set_t                   readData,      // Readback settings.
    output logic                          readValid,     // Readback answer pulse.
    output logic                          writeAck,      // Write accepted pulse.
    output logic                          writeRefused   // Write refused pulse.
);

    filter_set_t                   settingReg;
    logic [`NUM_INPUTS-1:0]        sync1Reg;
    logic [`NUM_INPUTS-1:0]        sync2Reg;
    logic [`NUM_INPUTS-1:0]        filtReg;
    logic [`CNT_W-1:0]             cntReg [`NUM_INPUTS];
    filter_set_t                   readReg;
    logic                          readValidReg;
    logic                          writeAckReg;
    logic                          writeRefusedReg;
    wire  logic                    writeAccept;
    wire  filter_set_t             readMasked;

    // A write is taken only in program mode; all groups update together.
    assign writeAccept = writeStrobe & programModeSetting; // see (R7) see (R9)
    // The six-input variant has no group 3, so it reads back as zero.
    assign readMasked = (VARIANT == `VARIANT_SIX) ?
                        {FILT_0MS, settingReg.group2, settingReg.group1} :
                        settingReg; // see (R11)

    // Settings register; the stored copy equals what the console sent.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            settingReg <= filter_set_t'(`SETTING_RESET);
        end else if (writeAccept) begin
            settingReg <= writeData; // see (R10)
        end
    end

    // Console answers: write handshake and readback in any mode.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            readReg         <= filter_set_t'(`SETTING_RESET);
            readValidReg    <= 1'b0;
            writeAckReg     <= 1'b0;
            writeRefusedReg <= 1'b0;
        end else begin
            readReg         <= readStrobe ? readMasked : readReg; // see (R8)
            readValidReg    <= readStrobe;
            writeAckReg     <= writeAccept;
            writeRefusedReg <= writeStrobe & ~programModeSetting; // see (R7)
        end
    end

    // Two-flop synchroniser on the raw terminals.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1Reg <= '0;
            sync2Reg <= '0;
        end else begin
            sync1Reg <= rawInputs;
            sync2Reg <= sync1Reg;
        end
    end

    // Maps an input index to its group for the chosen variant.
    function automatic logic [1:0] groupOf(input int idx);
        logic [1:0] g;
        g = 2'h0;
        unique case (VARIANT)
            `VARIANT_SIX:  g = (idx <= 2) ? 2'h0 : 2'h1;
            `VARIANT_TEN:  g = (idx <= 1) ? 2'h0 : ((idx <= 5) ? 2'h1 : 2'h2);
            default:       g = (idx <= 1) ? 2'h0 : ((idx <= 9) ? 2'h1 : 2'h2);
        endcase
        return g; // see (R6)
    endfunction

    // Maps a code to its qualification length in cycles.
    function automatic logic [`CNT_W-1:0] cyclesOf(input filter_code_t c);
        logic [`CNT_W-1:0] n;
        n = `CNT_W'(`CYC_0MS);
        unique case (c)
            FILT_0MS:  n = `CNT_W'(`CYC_0MS);
            FILT_1MS:  n = `CNT_W'(`CYC_1MS);
            FILT_5MS:  n = `CNT_W'(`CYC_5MS);
            FILT_10MS: n = `CNT_W'(`CYC_10MS);
        endcase
        return n; // see (R2) see (R3)
    endfunction

    // One qualification counter per input.
    genvar i;
    generate
        for (i = 0; i < `NUM_INPUTS; i++) begin : g_in
            wire logic [1:0]        grp;
            wire filter_code_t      code;
            wire logic [`CNT_W-1:0] limit;
            wire logic              differ;
            wire logic              done;
            assign grp    = groupOf(i);
            assign code   = (grp == 2'h0) ? settingReg.group1 :
                            (grp == 2'h1) ? settingReg.group2 : settingReg.group3; // see (R5)
            assign limit  = cyclesOf(code);
            assign differ = sync2Reg[i] ^ filtReg[i];
            assign done   = differ && (cntReg[i] >= limit - `CNT_W'(1));

            // Counts while the new level holds; any reversal restarts.
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    cntReg[i]  <= '0;
                    filtReg[i] <= 1'b0;
                end else if (!differ || done) begin
                    cntReg[i]  <= '0; // see (R13)
                    filtReg[i] <= done ? sync2Reg[i] : filtReg[i]; // see (R1) see (R4)
                end else begin
                    cntReg[i]  <= cntReg[i] + `CNT_W'(1);
                end
            end

            // A change needs limit consecutive differing cycles; the limit is taken from
            // the cycle before, so a setting written in that same cycle cannot upset it.
            shortPulse_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R1)
                $changed(filtReg[i]) |-> $past(cntReg[i]) == $past(limit) - `CNT_W'(1))
                else $error("Input changed before its qualification time.");
            reverseRestart_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R13)
                !differ |=> cntReg[i] == '0)
                else $error("Counter not cleared on reversal.");
            // The filtered level holds still in every cycle that does not qualify.
            filterHold_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R13)
                !done |=> $stable(filtReg[i]))
                else $error("Filtered level moved without qualification.");
        end
    endgenerate

    assign filteredInputs = filtReg;
    assign readData       = readReg;
    assign readValid      = readValidReg;
    assign writeAck       = writeAckReg;
    assign writeRefused   = writeRefusedReg;

    // Console side: a run-mode write leaves the settings alone and is refused.
    runRefuse_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R7)
        writeStrobe && !programModeSetting |=> $stable(settingReg) && writeRefused)
        else $error("Write taken in run mode.");
    settingHold_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R7)
        !writeAccept |=> $stable(settingReg))
        else $error("Settings moved without an accepted write.");
    refusePulse_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R7)
        !(writeStrobe && !programModeSetting) |=> !writeRefused)
        else $error("Refusal without a run-mode write.");
    ackExclusive_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R7)
        !(writeAck && writeRefused))
        else $error("Write both accepted and refused.");

    // An accepted write lands whole and is acknowledged exactly once.
    writeTake_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R10)
        writeAccept |=> settingReg == $past(writeData) && writeAck)
        else $error("Write not stored.");
    ackPulse_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R10)
        !writeAccept |=> !writeAck)
        else $error("Acknowledge without an accepted write.");

    // Readback answers every request in either mode, then holds until the next one.
    readBack_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R8)
        readStrobe |=> readValid && readData == $past(readMasked))
        else $error("Readback wrong.");
    readPulse_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R8)
        !readStrobe |=> !readValid)
        else $error("Readback answer without a request.");
    readHold_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R8)
        !readStrobe |=> $stable(readData))
        else $error("Readback data moved without a request.");
    sixGroups_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R11)
        (VARIANT == `VARIANT_SIX) && readValid |-> readData.group3 == FILT_0MS)
        else $error("Six-input readback reports group 3.");

    // Group mapping and count lengths, watched on inputs 0 and 5, whose group is the same in
    // every variant, and on input 11 for the ten millisecond count outside the six-input build.
    groupMap_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R6)
        g_in[0].code == settingReg.group1)
        else $error("Input 0 not in group 1.");
    groupMid_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R6)
        g_in[5].code == settingReg.group2)
        else $error("Input 5 not in group 2.");
    zeroCount_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R3)
        settingReg.group1 == FILT_0MS |-> g_in[0].limit == `CNT_W'(`CYC_0MS))
        else $error("Zero setting has the wrong count.");
    oneCount_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R2)
        settingReg.group1 == FILT_1MS |-> g_in[0].limit == `CNT_W'(`CYC_1MS))
        else $error("One millisecond setting has the wrong count.");
    fiveCount_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R2)
        settingReg.group2 == FILT_5MS |-> g_in[5].limit == `CNT_W'(`CYC_5MS))
        else $error("Five millisecond setting has the wrong count.");
    tenCount_a: assert property (@(posedge mclk) disable iff (!rst_n) // see (R2)
        (VARIANT != `VARIANT_SIX) && settingReg.group3 == FILT_10MS |->
            g_in[11].limit == `CNT_W'(`CYC_10MS))
        else $error("Ten millisecond setting has the wrong count.");

endmodule

// ---- input_filter_params.svh ----
/*
 * Constants for the grouped input debounce filter: timing, codes and widths.
 * Assumes a 250 MHz system clock; included by the package and the filter.
 */
`ifndef INPUT_FILTER_PARAMS_SVH
`define INPUT_FILTER_PARAMS_SVH

`define CLK_PERIOD_PS      4000
`define NUM_INPUTS         12
`define NUM_GROUPS         3
`define CODE_W             2
`define CNT_W              22
// Nominal minimum widths in microseconds.
`define TIME_0MS_US        150
`define TIME_1MS_US        1000
`define TIME_5MS_US        5000
`define TIME_10MS_US       10000
// Cycle counts, least times rounded up; worked in nanoseconds so no product overflows 32 bits.
`define CLK_PERIOD_NS      (`CLK_PERIOD_PS / 1000)
`define CYC_0MS   ((`TIME_0MS_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_1MS   ((`TIME_1MS_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_5MS   ((`TIME_5MS_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_10MS  ((`TIME_10MS_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Variant codes.
`define VARIANT_SIX        2'h0
`define VARIANT_TEN        2'h1
`define VARIANT_TWELVE     2'h2
`define SETTING_RESET      6'h00

`endif

// ---- input_filter_pkg.sv ----
/*
 * Types for the grouped input debounce filter.
 * Assumes the constants header is on the include path.
 */
`include "input_filter_params.svh"
package input_filter_pkg;
    typedef enum logic [1:0] {
        FILT_0MS  = 2'h0,
        FILT_1MS  = 2'h1,
        FILT_5MS  = 2'h2,
        FILT_10MS = 2'h3
    } filter_code_t;

    typedef struct packed {
        filter_code_t group3;
        filter_code_t group2;
        filter_code_t group1;
    } filter_set_t;
endpackage

// ---- tb_grouped_input_debounce_filter.sv ----
/*
 * Testbench for the grouped input debounce filter: console traffic and input qualification.
 * Assumes the default twelve-input variant, a 250 MHz clock and the console model beside it.
 */
module tb_grouped_input_debounce_filter import input_filter_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst_n = 1'b0, writeStrobe, readStrobe, programModeSetting;
    logic        readValid, writeAck, writeRefused;
    logic [11:0] rawInputs = 12'h000, filteredInputs;
    filter_set_t writeData, readData;
    int          errors = 0, samplesChecked = 0;

    // Clock of 4 ns period.
    always #2 mclk = ~mclk;

    grouped_input_debounce_filter i_dut (.mclk(mclk), .rst_n(rst_n), .rawInputs(rawInputs),
        .programModeSetting(programModeSetting), .writeStrobe(writeStrobe),
        .writeData(writeData), .readStrobe(readStrobe), .filteredInputs(filteredInputs),
        .readData(readData), .readValid(readValid), .writeAck(writeAck),
        .writeRefused(writeRefused));
    filter_console_model i_con (.mclk(mclk), .writeAck(writeAck), .writeRefused(writeRefused),
        .readValid(readValid), .readData(readData), .writeStrobe(writeStrobe),
        .writeData(writeData), .readStrobe(readStrobe),
        .programModeSetting(programModeSetting));

    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic ok, input string what);
        samplesChecked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("Error at %0t ns: %s", $time, what);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Refused run-mode write, accepted program write, readback in both modes.
    task automatic testConsole();
        filter_set_t q;
        logic        ok, ack, refd;
        i_con.readSettings(q, ok);
        chk(ok === 1'b1 && q === 6'h00, "reset readback wrong");
        i_con.sendSettings({FILT_10MS, FILT_5MS, FILT_1MS}, ack, refd);
        chk(refd === 1'b1 && ack !== 1'b1, "run mode write not refused");
        chk(i_con.heldCopy === 6'h00, "console copy moved on refusal");
        i_con.setMode(1'b1);
        i_con.sendSettings({FILT_10MS, FILT_5MS, FILT_1MS}, ack, refd);
        chk(ack === 1'b1 && refd !== 1'b1, "program mode write refused");
        i_con.readSettings(q, ok);
        chk(ok === 1'b1 && q === 6'h39, "readback wrong after write");
        chk(q === i_con.heldCopy, "device and console copies differ");
        i_con.sendSettings({FILT_1MS, FILT_0MS, FILT_1MS}, ack, refd);
        chk(ack === 1'b1 && refd !== 1'b1, "second program write refused");
        i_con.setMode(1'b0);
        i_con.readSettings(q, ok);
        chk(ok === 1'b1 && q === 6'h11, "run mode readback wrong");
        chk(q === i_con.heldCopy, "copies differ after second write");
    endtask

    // Short pulse with a reversal, then a long level; group 2 qualifies, groups 1 and 3 wait.
    task automatic testPulse();
        @(posedge mclk);
        #1 rawInputs = 12'hFFF;
        repeat (1000) @(posedge mclk);
        #1 rawInputs = 12'h000;
        repeat (100) @(posedge mclk);
        #1 rawInputs = 12'hFFF;
        repeat (37490) @(posedge mclk);
        #1 chk(filteredInputs === 12'h000, "early change passed");
        for (int i = 0; i < 60 && filteredInputs[9:2] !== 8'hFF; i++) begin
            @(posedge mclk);
            #1;
        end
        chk(filteredInputs[9:2] === 8'hFF, "group 2 level not detected");
        chk((filteredInputs & 12'hC03) === 12'h000, "group 1 or 3 moved");
    endtask

    // Reset for 10 cycles, then the scenarios in turn.
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        testConsole();
        testPulse();
        end_of_test();
    end

    // Watchdog reckoned from about 40k cycles of tests, with ample margin.
    initial begin
        #300000;
        errors++;
        end_of_test();
    end
endmodule
